// File: hdl/frontend_timer_control.sv
// Timer start/stop control and timer zero with its setup, reload and interrupt registers.
`timescale 1ns/1ns
`default_nettype none
module frontend_timer_control (
  input  wire logic        i_ref_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic      [31:0] o_wb_dat,
  output logic             o_wb_ack,
  input  wire logic        i_tx_end,
  input  wire logic        i_rx_nibble,
  input  wire logic        i_low_freq_oscillator,
  input  wire logic        i_timer_one_underflow,
  input  wire logic        i_timer_two_underflow,
  input  wire logic [2:0]  i_timer_upper_stop,
  output logic      [3:0]  o_timer_active,
  output logic             o_timer_zero_underflow,
  output logic      [15:0] o_count,
  output logic             o_irq
);

  //////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Byte address of a register index.
  function automatic logic [7:0] addr_of(input logic [5:0] idx);
    addr_of = {idx, 2'b00};
  endfunction : addr_of

  //////////////////////////////////////////////////////////////////////////////
  // State.

  frontend_timer_pkg::setup_type setup;
  logic [15:0]                   reload_count;
  logic [3:0]                    running;
  logic [1:0]                    irq_status;
  logic [1:0]                    irq_enable;
  logic                          lfo_prev;
  logic                          fast_tick;
  logic                          slow_tick;

  //////////////////////////////////////////////////////////////////////////////
  // Tick generators.

  tick_divider #(
    .INC(frontend_timer_pkg::FAST_INC)
  ) u_fast_tick (
    .i_ref_clk(i_ref_clk),
    .i_nrst   (i_nrst),
    .o_tick   (fast_tick)
  );

  tick_divider #(
    .INC(frontend_timer_pkg::SLOW_INC)
  ) u_slow_tick (
    .i_ref_clk(i_ref_clk),
    .i_nrst   (i_nrst),
    .o_tick   (slow_tick)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Wishbone decode.

  logic bus_req;
  logic bus_wr;
  logic hit_strobe;
  logic hit_setup;
  logic hit_rel_hi;
  logic hit_rel_lo;
  logic hit_cnt_hi;
  logic hit_cnt_lo;
  logic hit_status;
  logic hit_clear;
  logic hit_enable;

  // A request is taken while ack is low and answered one cycle later. A write lands only at the
  // edge where the master sees ack high, so a master that gives up early leaves no trace.
  // Writes need byte lane zero, because every register sits in the low byte.
  assign bus_req    = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  assign bus_wr     = i_wb_cyc & i_wb_stb & o_wb_ack & i_wb_we & i_wb_sel[0];
  assign hit_strobe = (i_wb_adr == addr_of(frontend_timer_pkg::IDX_RUN_STROBE));
  assign hit_setup  = (i_wb_adr == addr_of(frontend_timer_pkg::IDX_ZERO_SETUP));
  assign hit_rel_hi = (i_wb_adr == addr_of(frontend_timer_pkg::IDX_RELOAD_HI));
  assign hit_rel_lo = (i_wb_adr == addr_of(frontend_timer_pkg::IDX_RELOAD_LO));
  assign hit_cnt_hi = (i_wb_adr == addr_of(frontend_timer_pkg::IDX_COUNT_HI));
  assign hit_cnt_lo = (i_wb_adr == addr_of(frontend_timer_pkg::IDX_COUNT_LO));
  assign hit_status = (i_wb_adr == addr_of(frontend_timer_pkg::IDX_IRQ_STATUS));
  assign hit_clear  = (i_wb_adr == addr_of(frontend_timer_pkg::IDX_IRQ_CLEAR));
  assign hit_enable = (i_wb_adr == addr_of(frontend_timer_pkg::IDX_IRQ_ENABLE));

  // Readback; write-only fields, reserved bits and unmapped addresses read zero.
  // The count bytes are not latched together, so a running count read as two bytes may tear;
  // software should stop the timer first when it needs a consistent 16-bit value.
  logic [7:0] rd_byte;
  assign rd_byte = hit_strobe ? {running, 4'h0} :
                   hit_setup  ? (setup & frontend_timer_pkg::SETUP_WRITABLE) :
                   hit_rel_hi ? reload_count[15:8] :
                   hit_rel_lo ? reload_count[7:0] :
                   hit_cnt_hi ? o_count[15:8] :
                   hit_cnt_lo ? o_count[7:0] :
                   hit_status ? {6'h00, irq_status} :
                   hit_enable ? {6'h00, irq_enable} : 8'h00;

  //////////////////////////////////////////////////////////////////////////////
  // Start and stop sources of the shared run register.

  logic [3:0] sw_mask;
  logic [3:0] sw_value;

  // Only bits whose mask bit is written as one may change.
  assign sw_mask  = (bus_wr & hit_strobe) ? i_wb_dat[3:0] : 4'h0;
  assign sw_value = i_wb_dat[7:4];

  //////////////////////////////////////////////////////////////////////////////
  // Timer zero.

  logic lfo_mode;
  logic lfo_edge;
  logic tick;
  logic at_zero;
  logic underflow;
  logic auto_start;
  logic auto_stop;
  logic rx_halt;
  logic start_zero;
  logic next_run_zero;
  logic [15:0] next_count;

  assign lfo_mode = setup.auto_start_select[1];
  assign lfo_edge = i_low_freq_oscillator & ~lfo_prev;

  // Counting clock of timer zero.
  assign tick = (setup.tick_source_select == frontend_timer_pkg::TICK_FAST)     ? fast_tick :
                (setup.tick_source_select == frontend_timer_pkg::TICK_SLOW)     ? slow_tick :
                (setup.tick_source_select == frontend_timer_pkg::TICK_CASC_TWO) ? i_timer_two_underflow :
                i_timer_one_underflow;

  // Trimming without underflow parks the counter at zero instead of wrapping.
  assign at_zero   = (o_count == 16'h0000);
  assign underflow = running[0] & tick & at_zero &
                     (setup.auto_start_select != frontend_timer_pkg::START_LFO_HOLD);

  // A trimming edge starts an idle timer and stops a running one.
  assign auto_start = ((setup.auto_start_select == frontend_timer_pkg::START_TX_END) & i_tx_end) |
                      (lfo_mode & lfo_edge & ~running[0]);
  assign rx_halt    = setup.halt_on_receive & ~lfo_mode & i_rx_nibble & running[0];
  assign auto_stop  = rx_halt |
                      (lfo_mode & lfo_edge & running[0]) |
                      (underflow & ~setup.reload_on_zero);

  // Software has priority over automatic events in the same cycle.
  assign start_zero    = sw_mask[0] ? sw_value[0] : auto_start;
  assign next_run_zero = sw_mask[0] ? sw_value[0] :
                         auto_start ? 1'b1 :
                         auto_stop  ? 1'b0 : running[0];

  // The reload value is taken at a start event and at an auto-restart underflow. Priority, from the top: a start loads the
  // reload value, an idle or untriggered cycle holds, a tick above zero decrements, and a tick
  // at zero reloads only in auto-restart mode. Holding at zero without auto-restart is what lets
  // software read the final count after a one-shot.
  assign next_count = (start_zero & ~running[0]) | (start_zero & auto_start & ~sw_mask[0]) |
                      (sw_mask[0] & sw_value[0]) ? reload_count :
                      ~(running[0] & tick) ? o_count :
                      ~at_zero ? 16'(o_count - 16'h0001) :
                      (underflow & setup.reload_on_zero) ? reload_count : o_count;

  //////////////////////////////////////////////////////////////////////////////
  // Running bits of all four timers.

  logic [3:0] next_running;
  genvar gi;

  assign next_running[0] = next_run_zero;
  generate
    for (gi = 1; gi < frontend_timer_pkg::TIMERS; gi++) begin : g_upper
      // Upper timers stop themselves; a masked write still wins over their stop.
      assign next_running[gi] = sw_mask[gi] ? sw_value[gi] :
                                i_timer_upper_stop[gi-1] ? 1'b0 : running[gi];
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt registers.

  logic [1:0] irq_events;
  logic [1:0] irq_clr;
  logic [1:0] next_status;

  assign irq_events = {rx_halt, underflow};
  assign irq_clr    = (bus_wr & hit_clear) ? i_wb_dat[1:0] : 2'b00;
  // A new event in the clearing cycle survives the clear.
  assign next_status = (irq_status & ~irq_clr) | irq_events;

  //////////////////////////////////////////////////////////////////////////////
  // Register updates from the bus and from the timer logic.

  // Setup register; reserved bits are held at zero so that they always read back as zero.
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      setup <= frontend_timer_pkg::SETUP_RESET;
    end else if (bus_wr & hit_setup) begin
      setup <= i_wb_dat[7:0] & frontend_timer_pkg::SETUP_WRITABLE;
    end
  end

  // Reload bytes; a running count keeps going and only the next start or auto-restart reload picks them up.
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      reload_count <= frontend_timer_pkg::RELOAD_RESET;
    end else if (bus_wr & hit_rel_hi) begin
      reload_count[15:8] <= i_wb_dat[7:0];
    end else if (bus_wr & hit_rel_lo) begin
      reload_count[7:0] <= i_wb_dat[7:0];
    end
  end

  // Interrupt enable mask, same layout as the status register.
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      irq_enable <= 2'b00;
    end else if (bus_wr & hit_enable) begin
      irq_enable <= i_wb_dat[1:0];
    end
  end

  // Bus answer: ack one cycle after the request, dropped the cycle after.
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end else begin
      o_wb_ack <= bus_req;
      o_wb_dat <= bus_req ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // Running bits; the visible copy is its own flop so that the output comes straight from a register.
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      running        <= 4'h0;
      o_timer_active <= 4'h0;
    end else begin
      running        <= next_running;
      o_timer_active <= next_running;
    end
  end

  // Timer zero count.
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_count <= 16'h0000;
    end else begin
      o_count <= next_count;
    end
  end

  // Oscillator history for the rising-edge detector. An oscillator already high when reset
  // lifts gives one edge in the first cycle, so select a trimming mode only after that.
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      lfo_prev <= 1'b0;
    end else begin
      lfo_prev <= i_low_freq_oscillator;
    end
  end

  // Underflow pulse for cascading, one cycle after the tick at zero.
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_timer_zero_underflow <= 1'b0;
    end else begin
      o_timer_zero_underflow <= underflow;
    end
  end

  // Sticky status and the level interrupt, which follows the status in the same cycle.
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      irq_status <= 2'b00;
      o_irq      <= 1'b0;
    end else begin
      irq_status <= next_status;
      o_irq      <= |(next_status & irq_enable);
    end
  end

endmodule : frontend_timer_control
`default_nettype wire

// File: hdl/frontend_timer_pkg.sv
// Package with register map, field layouts and tick rates of the frontend timer control.
package frontend_timer_pkg;

  // Clock and tick rates in hertz.
  localparam longint CLK_HZ       = 20_000_000;
  localparam longint FAST_TICK_HZ = 13_560_000;
  localparam longint SLOW_TICK_HZ = 211_875;

  // Phase accumulator increments; tick rate equals increment / 2**ACC_W of the clock.
  localparam int          ACC_W    = 16;
  localparam logic [15:0] FAST_INC = 16'((FAST_TICK_HZ << ACC_W) / CLK_HZ);
  localparam logic [15:0] SLOW_INC = 16'((SLOW_TICK_HZ << ACC_W) / CLK_HZ);

  // Register indices; the byte address is four times the index.
  localparam logic [5:0] IDX_RUN_STROBE = 6'h0E;
  localparam logic [5:0] IDX_ZERO_SETUP = 6'h0F;
  localparam logic [5:0] IDX_RELOAD_HI  = 6'h10;
  localparam logic [5:0] IDX_RELOAD_LO  = 6'h11;
  localparam logic [5:0] IDX_COUNT_HI   = 6'h12;
  localparam logic [5:0] IDX_COUNT_LO   = 6'h13;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h20;
  localparam logic [5:0] IDX_IRQ_CLEAR  = 6'h21;
  localparam logic [5:0] IDX_IRQ_ENABLE = 6'h22;

  // Field positions of the shared run register.
  localparam int RUN_LSB  = 4;
  localparam int MASK_LSB = 0;
  localparam int TIMERS   = 4;

  // Interrupt status bit positions.
  localparam int IRQ_UNDERFLOW = 0;
  localparam int IRQ_RX_HALT   = 1;
  localparam int IRQ_BITS      = 2;

  // Reset values.
  localparam logic [7:0]  SETUP_RESET  = 8'h00;
  localparam logic [15:0] RELOAD_RESET = 16'h0000;

  // Writable bits of the setup register; bits 6 and 2 are reserved and stay zero.
  localparam logic [7:0]  SETUP_WRITABLE = 8'hBB;

  typedef enum logic [1:0] {
    START_NONE     = 2'b00,
    START_TX_END   = 2'b01,
    START_LFO_HOLD = 2'b10,
    START_LFO_WRAP = 2'b11
  } auto_start_type;

  typedef enum logic [1:0] {
    TICK_FAST      = 2'b00,
    TICK_SLOW      = 2'b01,
    TICK_CASC_TWO  = 2'b10,
    TICK_CASC_ONE  = 2'b11
  } tick_source_type;

  // Timer zero setup register layout, bit 7 down to bit 0.
  typedef struct packed {
    logic            halt_on_receive;
    logic            rfu_six;
    auto_start_type  auto_start_select;
    logic            reload_on_zero;
    logic            rfu_two;
    tick_source_type tick_source_select;
  } setup_type;

endpackage : frontend_timer_pkg

// File: hdl/tick_divider.sv
// Fractional tick generator producing one-cycle enable pulses.
`timescale 1ns/1ns
`default_nettype none
module tick_divider #(
  parameter logic [15:0] INC = 16'h0001
) (
  input  wire logic i_ref_clk,
  input  wire logic i_nrst,
  output logic      o_tick
);

  logic [15:0] acc;
  logic [16:0] next_sum;

  // The carry out of the accumulator gives an average rate of INC / 65536 of the clock.
  assign next_sum = {1'b0, acc} + {1'b0, INC};

  // Ticks jitter by one clock; only the mean rate is exact, which suits a timeout counter.
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      acc    <= 16'h0000;
      o_tick <= 1'b0;
    end else begin
      acc    <= next_sum[15:0];
      o_tick <= next_sum[16];
    end
  end

endmodule : tick_divider
`default_nettype wire

// File: verification/frontend_timer_control_sva.sv
// Port checker for the frontend timer control, bound to the top module.
`timescale 1ns/1ns
`default_nettype none
module frontend_timer_control_sva (
  input wire logic        i_ref_clk,
  input wire logic        i_nrst,
  input wire logic        i_wb_cyc,
  input wire logic        i_wb_stb,
  input wire logic        i_wb_we,
  input wire logic [7:0]  i_wb_adr,
  input wire logic [3:0]  i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  input wire logic [31:0] o_wb_dat,
  input wire logic        o_wb_ack,
  input wire logic [2:0]  i_timer_upper_stop,
  input wire logic [3:0]  o_timer_active,
  input wire logic [15:0] o_count,
  input wire logic        o_timer_zero_underflow
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  // A write to the run register landing at the ack edge; only lane 0 counts.
  wire logic run_wr = i_wb_cyc && i_wb_stb && i_wb_we && o_wb_ack && i_wb_sel[0] && i_wb_adr == 8'h38;
  ////////////////////////////////////////////////////////////////////////////
  a_ack_single:
    assert property (o_wb_ack |=> !o_wb_ack) else $error("ack held too long");
  a_ack_answer:
    assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack) else $error("request not answered");
  a_dat_idle:
    assert property (!o_wb_ack |-> o_wb_dat == 32'h0) else $error("read data outside ack");
  a_dat_upper_zero:
    assert property (o_wb_ack |-> o_wb_dat[31:8] == 24'h0) else $error("read data upper bits set");
  a_run_masked:
    assert property (run_wr |=> o_timer_active[3:1] == (($past(i_wb_dat[7:5]) & $past(i_wb_dat[3:1]))
      | ($past(o_timer_active[3:1]) & ~$past(i_wb_dat[3:1]) & ~$past(i_timer_upper_stop))))
      else $error("masked run write wrong");
  a_run_hold:
    assert property (!run_wr && i_timer_upper_stop == 3'h0 |=> $stable(o_timer_active[3:1]))
      else $error("running bits changed alone");
  a_upper_stop:
    assert property (!run_wr && i_timer_upper_stop[0] |=> !o_timer_active[1]) else $error("stop not shown");
  a_idle_count:
    assert property (!o_timer_active[0] ##1 !o_timer_active[0] |-> $stable(o_count))
      else $error("idle timer counted");
  a_uf_at_zero:
    assert property (o_timer_zero_underflow |-> $past(o_count) == 16'h0 || $past(o_count, 2) == 16'h0)
      else $error("underflow away from zero");
  // Main scenarios worth seeing at least once.
  c_run_write: cover property (run_wr);
  c_underflow: cover property (o_timer_zero_underflow);
  c_upper_stop: cover property (i_timer_upper_stop[0]);
endmodule : frontend_timer_control_sva
bind frontend_timer_control frontend_timer_control_sva u_sva (.i_ref_clk, .i_nrst, .i_wb_cyc, .i_wb_stb,
  .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack, .i_timer_upper_stop, .o_timer_active,
  .o_count, .o_timer_zero_underflow);
`default_nettype wire

// File: verification/tb_frontend_timer_control.sv
// Self-checking bench for the frontend timer control.
`timescale 1ns/1ns
`default_nettype none
module tb_frontend_timer_control;
  logic        i_ref_clk = 1'b0;
  logic        i_nrst = 1'b0;
  logic        i_wb_cyc = 1'b0;
  logic        i_wb_stb = 1'b0;
  logic        i_wb_we = 1'b0;
  logic [7:0]  i_wb_adr = 8'h00;
  logic [3:0]  i_wb_sel = 4'hF;
  logic [31:0] i_wb_dat = 32'h0;
  logic [4:0]  ev = 5'h00;
  logic [2:0]  i_timer_upper_stop = 3'h0;
  logic [31:0] o_wb_dat;
  logic        o_wb_ack;
  logic        o_timer_zero_underflow;
  logic        o_irq;
  logic [3:0]  o_timer_active;
  logic [15:0] o_count;
  int          error_cnt = 0;
  int          checks_done = 0;
  int          cycles = 0;

  // Events: 0 transmit end, 1 nibble, 2 oscillator, 3 and 4 cascade ticks.
  frontend_timer_control dut (.i_ref_clk, .i_nrst, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel,
    .i_wb_dat, .o_wb_dat, .o_wb_ack, .i_tx_end(ev[0]), .i_rx_nibble(ev[1]), .i_low_freq_oscillator(ev[2]),
    .i_timer_one_underflow(ev[3]), .i_timer_two_underflow(ev[4]), .i_timer_upper_stop, .o_timer_active,
    .o_timer_zero_underflow, .o_count, .o_irq);

  ////////////////////////////////////////////////////////////////////////////
  // Clock and a hang guard well above the fourteen hundred or so cycles the run needs.
  initial forever #25 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      end_sim();
    end
  end

  task automatic end_sim;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic chk_irq(input logic exp);
    checks_done++;
    if (o_irq !== exp) begin
      error_cnt++;
      $display("Error irq expected %b seen %b", exp, o_irq);
    end
  endtask : chk_irq

  // One classic cycle; the request stands until ack is sampled high.
  task automatic bus(input logic we, input logic [7:0] adr, input logic [7:0] dat, output logic [31:0] rdat);
    @(posedge i_ref_clk);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we  <= we;
    i_wb_adr <= adr;
    i_wb_dat <= {24'h0, dat};
    do @(posedge i_ref_clk); while (o_wb_ack !== 1'b1);
    rdat = o_wb_dat;
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
    logic [31:0] d;
    bus(1'b1, adr, dat, d);
  endtask : wr

  task automatic rd(input logic [7:0] adr, input logic [7:0] exp);
    logic [31:0] d;
    bus(1'b0, adr, 8'h00, d);
    chk($sformatf("reg %h", adr), {24'h0, exp}, d);
  endtask : rd

  task automatic pulse(input int k);
    @(posedge i_ref_clk);
    ev[k] <= 1'b1;
    @(posedge i_ref_clk);
    ev[k] <= 1'b0;
  endtask : pulse

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence; run register is 0x38, setup 0x3C, reload 0x40/0x44.
  initial begin
    repeat (10) @(posedge i_ref_clk);
    i_nrst <= 1'b1;
    rd(8'h38, 8'h00);
    rd(8'h3C, 8'h00);
    wr(8'h3C, 8'hFF);
    rd(8'h3C, 8'hBB);
    rd(8'h70, 8'h00);
    wr(8'h38, 8'hF0);
    rd(8'h38, 8'h00);
    wr(8'h38, 8'hFF);
    rd(8'h38, 8'hF0);
    @(posedge i_ref_clk);
    i_timer_upper_stop <= 3'h1;
    @(posedge i_ref_clk);
    i_timer_upper_stop <= 3'h0;
    rd(8'h38, 8'hD0);
    wr(8'h38, 8'h0F);
    rd(8'h38, 8'h00);
    // One-shot count on the timer one cascade; the new reload must wait.
    wr(8'h3C, 8'h03);
    wr(8'h44, 8'h02);
    wr(8'h88, 8'h01);
    wr(8'h38, 8'h11);
    rd(8'h4C, 8'h02);
    wr(8'h44, 8'h05);
    pulse(4);
    rd(8'h4C, 8'h02);
    pulse(3);
    rd(8'h4C, 8'h01);
    pulse(3);
    pulse(3);
    rd(8'h38, 8'h00);
    rd(8'h4C, 8'h00);
    rd(8'h80, 8'h01);
    chk_irq(1'b1);
    wr(8'h84, 8'h01);
    rd(8'h80, 8'h00);
    chk_irq(1'b0);
    // Reload on zero through the timer two cascade.
    wr(8'h44, 8'h01);
    wr(8'h3C, 8'h0A);
    wr(8'h38, 8'h11);
    pulse(4);
    pulse(4);
    rd(8'h38, 8'h10);
    rd(8'h4C, 8'h01);
    rd(8'h80, 8'h01);
    wr(8'h38, 8'h01);
    wr(8'h3C, 8'h83);
    wr(8'h38, 8'h11);
    pulse(1);
    rd(8'h38, 8'h00);
    // Both trimming modes ignore the nibble and toggle on oscillator edges.
    for (int m = 2; m < 4; m++) begin
      wr(8'h3C, {2'b10, 2'(m), 4'h3});
      wr(8'h38, 8'h11);
      pulse(1);
      rd(8'h38, 8'h10);
      pulse(2);
      rd(8'h38, 8'h00);
      pulse(2);
      rd(8'h38, 8'h10);
      wr(8'h38, 8'h01);
    end
    wr(8'h3C, 8'h03);
    pulse(0);
    rd(8'h38, 8'h00);
    wr(8'h3C, 8'h13);
    pulse(0);
    rd(8'h38, 8'h10);
    // Internal ticks: a long one-shot on the fast tick, then a short one on the slow tick.
    wr(8'h38, 8'h01);
    wr(8'h3C, 8'h00);
    wr(8'h40, 8'h01);
    wr(8'h44, 8'h80);
    wr(8'h38, 8'h11);
    rd(8'h48, 8'h01);
    repeat (700) @(posedge i_ref_clk);
    rd(8'h38, 8'h00);
    rd(8'h40, 8'h01);
    wr(8'h40, 8'h00);
    wr(8'h44, 8'h02);
    wr(8'h3C, 8'h01);
    wr(8'h38, 8'h11);
    repeat (40) @(posedge i_ref_clk);
    rd(8'h38, 8'h10);
    repeat (400) @(posedge i_ref_clk);
    rd(8'h38, 8'h00);
    end_sim();
  end
endmodule : tb_frontend_timer_control
`default_nettype wire
